/* File: core/system_status_reset_cause.sv */
// Function
// - bits 15-14 are reserved: read as zero, writes ignored
// - bits 13-11 mirror current clocking-scheme selection, reset to zero
// - bit 6 reads 1 while the mpu is idle, 0 while active
// - bit 5 set by power-on reset; write 0 clears, write 1 ignored
// - bit 4 set by external reset; write 0 clears, write 1 ignored
// - bit 3 read/write, 1 holds the mpu in reset, resets to 0
// - bit 2 set by mpu watchdog reset; cleared by pin or write 0
// - bit 1 set by global software reset; cleared by pin or write 0
// - bit 0 set by dsp watchdog reset; cleared by pin or write 0
// - global software reset only when mpu dsp-enable and mpu-reset bits both set
// - dsp-side software reset bit alone only raises the flag, no chip reset
module system_status_reset_cause
    import sysst_pkg::*;
(
    input wire logic mclk, // 20 MHz peripheral-bus clock
    input wire logic rst_n, // asynchronous reset, active low
    input wire logic [sysst_pkg::ADDR_W-1:0] bus_addr, // peripheral_bus byte offset
    input wire logic bus_wr, // peripheral_bus write strobe, one cycle
    input wire logic bus_rd, // peripheral_bus read strobe, one cycle
    input wire logic [sysst_pkg::DATA_W-1:0] bus_wdata, // write data
    input wire logic [sysst_pkg::CLKSEL_W-1:0] clock_select, // clocking scheme, async
    input wire logic mpu_idle, // mpu idle state, async
    input wire logic chip_reset_pin_n, // chip reset pin, async, active low
    input wire logic power_on_event, // cold start seen, one-cycle pulse
    input wire logic mpu_watchdog_event, // mpu watchdog underflow reset, pulse
    input wire logic dsp_watchdog_event, // dsp watchdog underflow reset, pulse
    input wire logic mpu_dsp_enable_bit, // dsp-enable bit of mpu_reset_control_one
    input wire logic mpu_reset_bit, // mpu-reset bit of mpu_reset_control_one
    input wire logic dsp_side_software_reset_bit, // bit of dsp_reset_control_one
    output logic [sysst_pkg::DATA_W-1:0] bus_rdata, // read data, registered
    output logic mpu_hold_reset, // holds the mpu in reset, registered
    output logic global_sw_reset // global software reset request, registered
);
    import sysst_pkg::*;

    // synchroniser stages
    logic [CLKSEL_W-1:0] clksel_meta_reg;
    logic [CLKSEL_W-1:0] clksel_reg;
    logic idle_meta_reg;
    logic idle_reg;
    logic pin_meta_reg;
    logic pin_sync_reg;
    logic pin_prev_reg;

    // sticky flags and the mpu hold bit
    logic power_on_flag_reg;
    logic external_reset_flag_reg;
    logic mpu_hold_reg;
    logic mpu_watchdog_reset_flag_reg;
    logic global_software_reset_flag_reg;
    logic dsp_watchdog_reset_flag_reg;

    // software request history and the registered chip reset request
    logic sw_bit_prev_reg;
    logic glob_req_prev_reg;
    logic global_sw_reset_reg;

    // registered read data
    logic [DATA_W-1:0] rdata_reg;

    // decode, set and clear terms and the read path
    logic hit_wr;
    logic hit_rd;
    logic pin_fall;
    logic glob_req;
    logic glob_req_rise;
    logic sw_bit_rise;
    logic glob_flag_set;
    logic power_on_set;
    logic power_on_clr;
    logic external_set;
    logic external_clr;
    logic mpu_wd_set;
    logic mpu_wd_clr;
    logic glob_clr;
    logic dsp_wd_set;
    logic dsp_wd_clr;
    logic [DATA_W-1:0] status_word;
    logic [DATA_W-1:0] rdata_next;

    // clocking-scheme level: two flops, only the second is read
    // the selection changes rarely, so two cycles of lag are harmless
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            clksel_meta_reg <= CLKSEL_RST;
            clksel_reg <= CLKSEL_RST;
        end else begin
            clksel_meta_reg <= clock_select;
            clksel_reg <= clksel_meta_reg;
        end
    end

    // mpu idle level: two flops, only the second is read
    // idle is only reported here, never acted on, so the lag costs nothing
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            idle_meta_reg <= MPU_IDLE_RST;
            idle_reg <= MPU_IDLE_RST;
        end else begin
            idle_meta_reg <= mpu_idle;
            idle_reg <= idle_meta_reg;
        end
    end

    // chip reset pin: two flops, only the second is read
    // the pin is asynchronous to mclk and may be slow or noisy at its edge
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta_reg <= SYNC_PIN_RST;
            pin_sync_reg <= SYNC_PIN_RST;
        end else begin
            pin_meta_reg <= chip_reset_pin_n;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // previous synchronised pin level for the fall detector
    // resets to the released level so leaving reset gives no false edge
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pin_prev_reg <= SYNC_PIN_RST;
        end else begin
            pin_prev_reg <= pin_sync_reg;
        end
    end

    // decode and event terms; edge detection reads only the second sync stage
    assign hit_wr = bus_wr && (bus_addr == SYSTEM_STATUS_RESET_CAUSE_OFS);
    assign hit_rd = bus_rd && (bus_addr == SYSTEM_STATUS_RESET_CAUSE_OFS);
    assign pin_fall = pin_prev_reg && !pin_sync_reg;
    assign glob_req = mpu_dsp_enable_bit && mpu_reset_bit;

    // rising edges only, so a request held high flags once, not every cycle
    assign glob_req_rise = glob_req && !glob_req_prev_reg;
    assign sw_bit_rise = dsp_side_software_reset_bit && !sw_bit_prev_reg;
    assign glob_flag_set = glob_req_rise || sw_bit_rise;

    // set sources, one per flag
    assign power_on_set = power_on_event;
    assign external_set = pin_fall;
    assign mpu_wd_set = mpu_watchdog_event;
    assign dsp_wd_set = dsp_watchdog_event;

    // write-zero clears, one per flag
    // a written one matches no clear term, so the bus can never set a flag
    assign power_on_clr = hit_wr && !bus_wdata[POWER_ON_FLAG_BIT];
    assign external_clr = hit_wr && !bus_wdata[EXTERNAL_RESET_FLAG_BIT];

    assign mpu_wd_clr = pin_fall || (hit_wr && !bus_wdata[MPU_WATCHDOG_FLAG_BIT]);
    assign glob_clr = pin_fall || (hit_wr && !bus_wdata[GLOBAL_SW_FLAG_BIT]);
    assign dsp_wd_clr = pin_fall || (hit_wr && !bus_wdata[DSP_WATCHDOG_FLAG_BIT]);

    // dsp-side request history for its rising edge
    // resets low, so a request already high at release still flags once
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sw_bit_prev_reg <= 1'b0;
        end else begin
            sw_bit_prev_reg <= dsp_side_software_reset_bit;
        end
    end

    // mpu pair request history for its rising edge
    // same reset choice as the dsp side, for the same reason
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            glob_req_prev_reg <= 1'b0;
        end else begin
            glob_req_prev_reg <= glob_req;
        end
    end

    // chip reset only from the mpu pair
    // registered so the request leaving the block is free of decode glitches
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            global_sw_reset_reg <= 1'b0;
        end else begin
            global_sw_reset_reg <= glob_req;
        end
    end

    // cleared only by its own zero; a set in the same cycle wins
    // the power-on source is a one-cycle pulse from the reset sequencer
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            power_on_flag_reg <= FLAG_RST;
        end else if (power_on_set) begin
            power_on_flag_reg <= 1'b1;
        end else if (power_on_clr) begin
            power_on_flag_reg <= 1'b0;
        end
    end

    // external reset flag sticky
    // the pin assertion edge is the set source, so it is never cleared by it
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            external_reset_flag_reg <= FLAG_RST;
        end else if (external_set) begin
            external_reset_flag_reg <= 1'b1;
        end else if (external_clr) begin
            external_reset_flag_reg <= 1'b0;
        end
    end

    // mpu hold-in-reset control bit
    // only meant for test and debug, so no interlock against misuse
    // every write to the offset rewrites the bit, as it is plain read/write
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            mpu_hold_reg <= MPU_HOLD_RESET_RST;
        end else if (hit_wr) begin
            mpu_hold_reg <= bus_wdata[MPU_HOLD_RESET_BIT];
        end
    end

    // mpu watchdog flag: set beats pin and write clears
    // an underflow in the cycle of a clearing write must not be lost
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            mpu_watchdog_reset_flag_reg <= FLAG_RST;
        end else if (mpu_wd_set) begin
            mpu_watchdog_reset_flag_reg <= 1'b1;
        end else if (mpu_wd_clr) begin
            mpu_watchdog_reset_flag_reg <= 1'b0;
        end
    end

    // global software flag: set beats pin and write clears
    // a request in the cycle of a clearing write must not be lost
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            global_software_reset_flag_reg <= FLAG_RST;
        end else if (glob_flag_set) begin
            global_software_reset_flag_reg <= 1'b1;
        end else if (glob_clr) begin
            global_software_reset_flag_reg <= 1'b0;
        end
    end

    // dsp watchdog flag: set beats pin and write clears
    // an underflow in the cycle of a clearing write must not be lost
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            dsp_watchdog_reset_flag_reg <= FLAG_RST;
        end else if (dsp_wd_set) begin
            dsp_watchdog_reset_flag_reg <= 1'b1;
        end else if (dsp_wd_clr) begin
            dsp_watchdog_reset_flag_reg <= 1'b0;
        end
    end

    // read word assembly; unlisted bits stay zero
    always_comb begin
        status_word = '0;
        status_word[CLKSEL_MSB:CLKSEL_LSB] = clksel_reg;
        status_word[MPU_IDLE_BIT] = idle_reg;
        status_word[POWER_ON_FLAG_BIT] = power_on_flag_reg;
        status_word[EXTERNAL_RESET_FLAG_BIT] = external_reset_flag_reg;
        status_word[MPU_HOLD_RESET_BIT] = mpu_hold_reg;
        status_word[MPU_WATCHDOG_FLAG_BIT] = mpu_watchdog_reset_flag_reg;
        status_word[GLOBAL_SW_FLAG_BIT] = global_software_reset_flag_reg;
        status_word[DSP_WATCHDOG_FLAG_BIT] = dsp_watchdog_reset_flag_reg;
        // reserved fields keep the zero set above
    end

    // read mux, reserved and unmapped zero
    // zero rather than undefined keeps repeated reads comparable for software
    always_comb begin
        rdata_next = RDATA_RST;
        if (hit_rd) begin
            rdata_next = status_word;
        end else begin
            // unmapped offset
            rdata_next = RDATA_RST;
        end
    end

    // reserved bits read zero
    // read data holds until the next read; unmapped offsets return zero
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg <= RDATA_RST;
        end else if (bus_rd) begin
            rdata_reg <= rdata_next;
        end
    end

    // read data straight from its flop
    assign bus_rdata = rdata_reg;
    // hold level straight from its flop
    assign mpu_hold_reset = mpu_hold_reg;
    // chip reset request straight from its flop
    assign global_sw_reset = global_sw_reset_reg;
endmodule // system_status_reset_cause

/* File: common/sysst_pkg.sv */
// shared constants for the dsp-side system status and reset-cause register
package sysst_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned CLKSEL_W = 3;

    // register offset on the peripheral bus
    localparam logic [ADDR_W-1:0] SYSTEM_STATUS_RESET_CAUSE_OFS = 8'h18;

    // field positions
    localparam int unsigned CLKSEL_LSB = 11;
    localparam int unsigned CLKSEL_MSB = 13;
    localparam int unsigned MPU_IDLE_BIT = 6;
    localparam int unsigned POWER_ON_FLAG_BIT = 5;
    localparam int unsigned EXTERNAL_RESET_FLAG_BIT = 4;
    localparam int unsigned MPU_HOLD_RESET_BIT = 3;
    localparam int unsigned MPU_WATCHDOG_FLAG_BIT = 2;
    localparam int unsigned GLOBAL_SW_FLAG_BIT = 1;
    localparam int unsigned DSP_WATCHDOG_FLAG_BIT = 0;

    // reset values
    localparam logic [CLKSEL_W-1:0] CLKSEL_RST = 3'h0;
    localparam logic MPU_IDLE_RST = 1'b0;
    localparam logic FLAG_RST = 1'b0;
    localparam logic MPU_HOLD_RESET_RST = 1'b0;
    localparam logic [DATA_W-1:0] RDATA_RST = 16'h0000;
    localparam logic SYNC_PIN_RST = 1'b1;
endpackage : sysst_pkg

/* File: verification/sysst_asserts.sv */
// watches the status register ports; reads are registered one cycle
module sysst_asserts
    import sysst_pkg::*;
(
    input wire logic mclk, // clock
    input wire logic rst_n, // reset
    input wire logic [sysst_pkg::ADDR_W-1:0] bus_addr, // offset
    input wire logic bus_wr, // write
    input wire logic bus_rd, // read
    input wire logic [sysst_pkg::DATA_W-1:0] bus_wdata, // wdata
    input wire logic [sysst_pkg::CLKSEL_W-1:0] clock_select, // scheme
    input wire logic mpu_idle, // idle
    input wire logic mpu_watchdog_event, // pulse
    input wire logic mpu_dsp_enable_bit, // pair
    input wire logic mpu_reset_bit, // pair
    input wire logic dsp_side_software_reset_bit, // flag only
    input wire logic [sysst_pkg::DATA_W-1:0] bus_rdata, // rdata
    input wire logic mpu_hold_reset, // hold
    input wire logic global_sw_reset // request
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // accesses that hit the status offset
    wire logic rd18 = bus_rd && bus_addr == SYSTEM_STATUS_RESET_CAUSE_OFS;
    wire logic wr18 = bus_wr && bus_addr == SYSTEM_STATUS_RESET_CAUSE_OFS;
    property p_hold; wr18 |=> mpu_hold_reset == $past(bus_wdata[MPU_HOLD_RESET_BIT]); endproperty
    a_hold: assert property (p_hold) else $error("hold bit not written");
    property p_gsw; 1 |=> global_sw_reset == $past(mpu_dsp_enable_bit && mpu_reset_bit); endproperty
    a_gsw: assert property (p_gsw) else $error("reset request wrong");
    property p_swonly;
        dsp_side_software_reset_bit && !(mpu_dsp_enable_bit && mpu_reset_bit) |=> !global_sw_reset;
    endproperty
    a_swonly: assert property (p_swonly) else $error("flag-only request reset chip");
    property p_rsvd; bus_rd |=> bus_rdata[15:14] == 2'h0 && bus_rdata[10:7] == 4'h0; endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
    property p_unmap; bus_rd && !rd18 |=> bus_rdata == 16'h0000; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_wdog; mpu_watchdog_event ##2 rd18 |=> bus_rdata[2]; endproperty
    a_wdog: assert property (p_wdog) else $error("watchdog flag not set");
    // the selection crosses two sync flops, so it must settle before a read
    property p_csel; $stable(clock_select)[*3] ##0 rd18 |=> bus_rdata[13:11] == $past(clock_select); endproperty
    a_csel: assert property (p_csel) else $error("scheme field wrong");
    property p_idle; $stable(mpu_idle)[*3] ##0 rd18 |=> bus_rdata[6] == $past(mpu_idle); endproperty
    a_idle: assert property (p_idle) else $error("idle bit wrong");
endmodule // sysst_asserts

bind system_status_reset_cause sysst_asserts u_sysst_asserts (.mclk, .rst_n, .bus_addr, .bus_wr,
    .bus_rd, .bus_wdata, .clock_select, .mpu_idle, .mpu_watchdog_event, .mpu_dsp_enable_bit,
    .mpu_reset_bit, .dsp_side_software_reset_bit, .bus_rdata, .mpu_hold_reset, .global_sw_reset);

/* File: verification/system_status_reset_cause_test.sv */
module system_status_reset_cause_test import sysst_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [ADDR_W-1:0] addr = 8'h00;
    logic wr = 1'b0, rd = 1'b0, idle = 1'b0, pin_n = 1'b1, swr = 1'b0, den = 1'b0, mrst = 1'b0;
    logic [DATA_W-1:0] wdata = 16'h0000;
    logic [DATA_W-1:0] rdata;
    logic [CLKSEL_W-1:0] csel = 3'h0;
    logic [2:0] ev = 3'h0; // power-on, mpu watchdog, dsp watchdog
    logic hold, gsr;
    int n_errors = 0, total_checks = 0;
    system_status_reset_cause u_dut (.mclk(mclk), .rst_n(rst_n), .bus_addr(addr), .bus_wr(wr),
        .bus_rd(rd), .bus_wdata(wdata), .clock_select(csel), .mpu_idle(idle),
        .chip_reset_pin_n(pin_n), .power_on_event(ev[2]), .mpu_watchdog_event(ev[1]),
        .dsp_watchdog_event(ev[0]), .mpu_dsp_enable_bit(den), .mpu_reset_bit(mrst),
        .dsp_side_software_reset_bit(swr), .bus_rdata(rdata), .mpu_hold_reset(hold),
        .global_sw_reset(gsr));
    // 20 MHz clock
    always #25 mclk = ~mclk;
    task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge mclk);
    endtask
    // wr_reg, rd_chk and pulse open on a fresh edge so no strobe is driven twice in one step
    task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    // read data is compared at the falling edge, well after it settles
    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        @(negedge mclk);
        chk(rdata, e);
    endtask
    task automatic pulse(input logic [2:0] v);
        @(posedge mclk);
        ev <= v;
        @(posedge mclk);
        ev <= 3'h0;
    endtask
    task automatic close_out();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // main sequence; written ones on flags must never set them
    initial begin
        wt(12);
        rst_n <= 1'b1;
        rd_chk(8'h18, 16'h0000);
        pulse(3'h4);
        rd_chk(8'h18, 16'h0020);
        wr_reg(8'h18, 16'hFFFF);
        rd_chk(8'h18, 16'h0028);
        chk(16'(hold), 16'h0001);
        pulse(3'h3);
        rd_chk(8'h18, 16'h002D);
        wr_reg(8'h18, 16'hFFDB);
        rd_chk(8'h18, 16'h0009);
        @(posedge mclk);
        swr <= 1'b1;
        wt(3);
        rd_chk(8'h18, 16'h000B);
        chk(16'(gsr), 16'h0000);
        @(posedge mclk);
        swr <= 1'b0;
        pin_n <= 1'b0;
        wt(5);
        pin_n <= 1'b1;
        wt(5);
        rd_chk(8'h18, 16'h0018);
        @(posedge mclk);
        den <= 1'b1;
        mrst <= 1'b1;
        wt(2);
        @(negedge mclk);
        chk(16'(gsr), 16'h0001);
        @(posedge mclk);
        den <= 1'b0;
        mrst <= 1'b0;
        csel <= 3'h5;
        idle <= 1'b1;
        wt(4);
        rd_chk(8'h18, 16'h285A);
        rd_chk(8'h1C, 16'h0000);
        wr_reg(8'h1C, 16'h0000);
        rd_chk(8'h18, 16'h285A);
        wr_reg(8'h18, 16'h0000);
        rd_chk(8'h18, 16'h2840);
        chk(16'(hold), 16'h0000);
        close_out();
    end
    // watchdog: the sequence needs about 70 cycles
    initial begin
        wt(400);
        n_errors++;
        close_out();
    end
endmodule // system_status_reset_cause_test
